//--- pkg/timer_pkg.sv
// shared constants, carriers and mode codes for the capture/reload timer
package timer_pkg;

  // ****************************************************************
  // widths and count values
  // ****************************************************************
  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_MAX      = 16'hffff;  // roll-over point / underflow load
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // ****************************************************************
  // clock and divider figures
  // ****************************************************************
  localparam int CLK_FREQ_MHZ   = 200;  // system clock, treated as the oscillator
  localparam int CLK_PERIOD_NS  = 5;
  localparam int MACH_DIV       = 12;   // oscillator periods per machine cycle
  localparam int CLKOUT_DIV     = 2;    // oscillator periods per fast step
  localparam int CLKOUT_STEP_NS = CLKOUT_DIV * CLK_PERIOD_NS;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic run_control;
    logic counter_select;           // 1: count falling edges on the count clock pin
    logic capture_mode;             // 1: capture, 0: auto-reload
    logic external_trigger_enable;
    logic down_count_enable;
    logic clock_out_enable;
    logic baud_mode;                // counter also serves as baud-rate generator
  } timer_ctrl_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } byte_pair_t;

  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
  } timer_flags_t;

  localparam timer_flags_t FLAGS_RESET = '{overflow_flag: 1'b0, external_event_flag: 1'b0};

  // ****************************************************************
  // operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_CAPTURE   = 2'b00,
    MODE_RELOAD_UP = 2'b01,
    MODE_UPDOWN    = 2'b10,
    MODE_FAST      = 2'b11   // clock-out and/or baud generation
  } timer_mode_t;

endpackage : timer_pkg

//--- test/pin_partner.sv
// far side: pulled-up trigger/direction driver and clock-out load
`timescale 1ns/1ps
module pin_partner (
  input  wire logic clk_in,
  input  wire logic trig_low_in,
  input  wire logic clk_pin_in,
  output logic      trig_pin_out,
  output int        period_out
);
  int   cnt  = 0;
  logic last = 1'b1;
  // line rests high by its pull-up, low only while pulled
  assign trig_pin_out = trig_low_in ? 1'b0 : 1'b1;
  // cycles between rising edges of the clock-out pin
  always @(posedge clk_in) begin
    cnt  <= cnt + 1;
    last <= clk_pin_in;
    if (clk_pin_in && !last) begin
      period_out <= cnt;
      cnt        <= 1;
    end
  end
endmodule : pin_partner

//--- test/tb.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic         clk, srst, count_wr, reload_wr, irq_en, trig_low, pin_out, pin_oe, irq, baud;
  logic         cnt_low;
  timer_ctrl_t  ctrl;
  byte_pair_t   count_wd, reload_wd, count_q, reload_q;
  timer_flags_t clr, flags;
  wire          trig_pin;
  wire          count_pin = pin_oe ? pin_out : (cnt_low ? 1'b0 : 1'b1); // pulled-up shared pin
  int           period, ticks = 0, errors = 0, checks = 0, cycles = 0;

  capture_reload_timer #(.MACH_DIV_P(2), .CLKOUT_DIV_P(2)) i_capture_reload_timer (
    .CLK_SYS_IN(clk), .SRST_IN(srst), .CTRL_IN(ctrl),
    .COUNT_WR_IN(count_wr), .COUNT_WDATA_IN(count_wd),
    .RELOAD_WR_IN(reload_wr), .RELOAD_WDATA_IN(reload_wd),
    .FLAG_CLR_IN(clr), .IRQ_ENABLE_IN(irq_en),
    .TRIG_DIR_PIN_IN(trig_pin), .COUNT_CLK_PIN_IN(count_pin),
    .COUNT_CLK_PIN_OUT(pin_out), .COUNT_CLK_PIN_OE_OUT(pin_oe),
    .COUNT_OUT(count_q), .RELOAD_OUT(reload_q), .FLAGS_OUT(flags),
    .IRQ_OUT(irq), .BAUD_TICK_OUT(baud));
  pin_partner i_pin_partner (.clk_in(clk), .trig_low_in(trig_low), .clk_pin_in(count_pin),
    .trig_pin_out(trig_pin), .period_out(period));

  // clock, cycle ceiling and baud tick count
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (baud === 1'b1) ticks <= ticks + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic rel, input logic [15:0] v);
    @(negedge clk);
    count_wr  = ~rel;
    reload_wr = rel;
    count_wd  = v;
    reload_wd = v;
    @(negedge clk);
    count_wr  = 1'b0;
    reload_wr = 1'b0;
  endtask : wr

  task automatic clear_flags(input timer_flags_t f);
    @(negedge clk);
    clr = f;
    @(negedge clk);
    clr = 2'b00;
  endtask : clear_flags

  task automatic wait_on(input int b);
    int n;
    n = 0;
    while (flags[b] !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("flag set", 16'h0001, {15'h0, flags[b]});
  endtask : wait_on

  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    srst = 1'b1; ctrl = '0; count_wr = 1'b0; reload_wr = 1'b0; count_wd = '0;
    reload_wd = '0; clr = '0; irq_en = 1'b0; trig_low = 1'b0;
    cnt_low = 1'b0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    chk("count reset", 16'h0000, count_q);
    chk("flags reset", 16'h0000, {14'h0, flags});
    wr(1'b1, 16'hfff0);
    wr(1'b0, 16'hfffd);
    irq_en = 1'b1;
    ctrl.run_control = 1'b1;
    wait_on(1);
    chk("up reload", 16'hfff0, count_q);
    chk("up irq", 16'h0001, {15'h0, irq});
    ctrl.run_control = 1'b0;
    wr(1'b0, 16'h0042);
    repeat (20) @(negedge clk);
    chk("stopped", 16'h0042, count_q);
    clear_flags(2'b11);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    ctrl.external_trigger_enable = 1'b1;
    ctrl.run_control = 1'b1;
    trig_low = 1'b1;
    wait_on(0);
    chk("trigger reload", 16'hfff0, count_q);
    chk("event irq", 16'h0001, {15'h0, irq});
    ctrl.external_trigger_enable = 1'b0;
    ctrl.capture_mode = 1'b1;
    trig_low = 1'b0;
    clear_flags(2'b11);
    repeat (10) @(negedge clk);
    trig_low = 1'b1;
    repeat (20) @(negedge clk);
    chk("fall ignored", 16'h0000, {15'h0, flags.external_event_flag});
    chk("no capture", 16'hfff0, reload_q);
    clear_flags(2'b11);
    wr(1'b0, 16'hfffe);
    wait_on(1);
    chk("capture wrap", 16'h0000, count_q);
    clear_flags(2'b10);
    trig_low = 1'b0;
    ctrl.external_trigger_enable = 1'b1;
    repeat (10) @(negedge clk);
    trig_low = 1'b1;
    wait_on(0);
    chk("capture", 16'h0001, {15'h0, (count_q - reload_q) <= 16'h0001});
    chk("capture irq", 16'h0001, {15'h0, irq});
    ctrl.capture_mode = 1'b0;
    ctrl.external_trigger_enable = 1'b0;
    ctrl.down_count_enable = 1'b1;
    wr(1'b1, 16'h0100);
    wr(1'b0, 16'h0104);
    clear_flags(2'b11);
    wait_on(1);
    chk("underflow", 16'hffff, count_q);
    chk("17th bit set", 16'h0001, {15'h0, flags.external_event_flag});
    clear_flags(2'b10);
    chk("no event irq", 16'h0000, {15'h0, irq});
    trig_low = 1'b0;
    wait_on(1);
    chk("up overflow", 16'h0100, count_q);
    chk("17th bit back", 16'h0000, {15'h0, flags.external_event_flag});
    clear_flags(2'b11);
    ctrl = '0;
    ctrl.counter_select = 1'b1;
    ctrl.capture_mode = 1'b1;
    ctrl.run_control = 1'b1;
    wr(1'b0, 16'h0000);
    repeat (3) begin
      cnt_low = 1'b1;
      repeat (6) @(negedge clk);
      cnt_low = 1'b0;
      repeat (6) @(negedge clk);
    end
    chk("pin count", 16'h0003, count_q);
    ctrl = '0;
    ctrl.clock_out_enable = 1'b1;
    ctrl.baud_mode = 1'b1;
    ctrl.run_control = 1'b1;
    wr(1'b1, 16'hfff8);
    wr(1'b0, 16'hfff8);
    repeat (100) @(negedge clk);
    ticks = 0;
    repeat (64) @(negedge clk);
    chk("pin driven", 16'h0001, {15'h0, pin_oe});
    chk("clock period", 16'h0020, period[15:0]);
    chk("baud ticks", 16'h0004, ticks[15:0]);
    chk("no flags", 16'h0000, {14'h0, flags});
    stop_test();
  end
endmodule : tb

//--- test/timer_monitor.sv
// concurrent checks on the capture/reload timer ports
`timescale 1ns/1ps
module timer_monitor
  import timer_pkg::*;
#(
  parameter int MACH_DIV_P   = 12,
  parameter int CLKOUT_DIV_P = 2
) (
  input wire logic                    CLK_SYS_IN,
  input wire logic                    SRST_IN,
  input wire timer_pkg::timer_ctrl_t  CTRL_IN,
  input wire logic                    COUNT_WR_IN,
  input wire logic                    RELOAD_WR_IN,
  input wire timer_pkg::timer_flags_t FLAG_CLR_IN,
  input wire logic                    IRQ_ENABLE_IN,
  input wire logic                    COUNT_CLK_PIN_OE_OUT,
  input wire timer_pkg::byte_pair_t   COUNT_OUT,
  input wire timer_pkg::byte_pair_t   RELOAD_OUT,
  input wire timer_pkg::timer_flags_t FLAGS_OUT,
  input wire logic                    IRQ_OUT
);
  import timer_pkg::*;
  // mode decode as the design applies it
  wire fast  = (CTRL_IN.clock_out_enable & ~CTRL_IN.counter_select) | CTRL_IN.baud_mode;
  wire cap_m = ~fast & CTRL_IN.capture_mode;
  wire ud_m  = ~fast & ~CTRL_IN.capture_mode & CTRL_IN.down_count_enable;
  wire up_m  = ~fast & ~CTRL_IN.capture_mode & ~CTRL_IN.down_count_enable;
  wire run   = CTRL_IN.run_control;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  reset_clear_a:
    assert property (disable iff (1'b0) SRST_IN |=> COUNT_OUT == 16'h0000 && !IRQ_OUT)
    else $error("count or irq not cleared by reset");
  oe_decode_a:
    assert property (COUNT_CLK_PIN_OE_OUT == (CTRL_IN.clock_out_enable & ~CTRL_IN.counter_select))
    else $error("clock pin enable wrong");
  run_hold_a:
    assert property (!run && !CTRL_IN.external_trigger_enable && !COUNT_WR_IN |=> $stable(COUNT_OUT))
    else $error("count moved while stopped");
  fast_noflag_a:
    assert property (fast && run |=> !$rose(FLAGS_OUT.overflow_flag))
    else $error("roll-over flag in fast mode");
  up_reload_a:
    assert property (up_m && run && COUNT_OUT == CNT_MAX && !COUNT_WR_IN && !RELOAD_WR_IN
      && !CTRL_IN.external_trigger_enable |=> COUNT_OUT == CNT_MAX
      || (COUNT_OUT == $past(RELOAD_OUT) && FLAGS_OUT.overflow_flag)) else $error("bad reload");
  ud_under_a:
    assert property (ud_m && run && COUNT_OUT == RELOAD_OUT && COUNT_OUT != CNT_MAX && !COUNT_WR_IN
      |=> COUNT_OUT == $past(COUNT_OUT) || COUNT_OUT == CNT_MAX
      || COUNT_OUT == $past(COUNT_OUT) + 16'h0001) else $error("bad underflow");
  flag_hold_a:
    assert property (FLAGS_OUT.overflow_flag && !FLAG_CLR_IN.overflow_flag
      |=> FLAGS_OUT.overflow_flag) else $error("flag dropped without clear");
  irq_follow_a:
    assert property (up_m && IRQ_ENABLE_IN ##1 FLAGS_OUT != 2'b00 |-> IRQ_OUT)
    else $error("irq missing");
  irq_mask_a:
    assert property (!IRQ_ENABLE_IN |=> !IRQ_OUT)
    else $error("irq while disabled");
  ud_noirq_a:
    assert property (ud_m ##1 !FLAGS_OUT.overflow_flag |-> !IRQ_OUT)
    else $error("event flag raised irq in up/down");
  capture_copy_a:
    assert property (cap_m && !RELOAD_WR_IN ##1 $changed(RELOAD_OUT)
      |-> RELOAD_OUT == $past(COUNT_OUT) && FLAGS_OUT.external_event_flag)
    else $error("bad capture");
  cover property (cap_m ##1 $rose(FLAGS_OUT.external_event_flag));
  cover property (ud_m && COUNT_OUT == RELOAD_OUT ##1 COUNT_OUT == CNT_MAX);
  cover property (up_m ##1 $rose(IRQ_OUT));
endmodule : timer_monitor

bind capture_reload_timer timer_monitor #(.MACH_DIV_P(MACH_DIV_P), .CLKOUT_DIV_P(CLKOUT_DIV_P))
  i_timer_monitor (
    .CLK_SYS_IN           (CLK_SYS_IN),
    .SRST_IN              (SRST_IN),
    .CTRL_IN              (CTRL_IN),
    .COUNT_WR_IN          (COUNT_WR_IN),
    .RELOAD_WR_IN         (RELOAD_WR_IN),
    .FLAG_CLR_IN          (FLAG_CLR_IN),
    .IRQ_ENABLE_IN        (IRQ_ENABLE_IN),
    .COUNT_CLK_PIN_OE_OUT (COUNT_CLK_PIN_OE_OUT),
    .COUNT_OUT            (COUNT_OUT),
    .RELOAD_OUT           (RELOAD_OUT),
    .FLAGS_OUT            (FLAGS_OUT),
    .IRQ_OUT              (IRQ_OUT)
  );

//--- verilog/capture_reload_timer.sv
// sixteen-bit capture / auto-reload / clock-out timer
//
// What this block does
// - Capture mode without trigger: plain 16-bit counter, overflow sets overflow flag.
// - Capture mode with trigger: pin falling edge copies count into reload pair.
// - Capture-mode pin falling edge also sets the external event flag, which can interrupt.
// - Reset masks down-count enable only while asserted; afterwards the mode follows CTRL_IN.
// - Up auto-reload: count to ffff, overflow sets flag and loads reload pair.
// - Up auto-reload with trigger: overflow or pin fall reloads; fall sets event flag.
// - Up auto-reload: both flags request an interrupt when enabled.
// - Up/down with pin high: count up, ffff overflow sets flag, loads reload pair.
// - Up/down with pin low: count down, match with reload sets flag, loads ffff.
// - Up/down: event flag toggles each over/underflow as 17th bit, no interrupt.
// - Counter select clear and clock-out enable set drive 50% clock on pin.
// - Run control starts and stops the timer, clock-out included.
// - Clock-out frequency is oscillator over four times (65536 minus reload).
// - Clock-out roll-overs raise no interrupt request.
// - Baud generation and clock-out run together sharing the reload pair.
// - Trigger pin is trigger and direction; count pin is count input and clock output.
`timescale 1ns/1ps
module capture_reload_timer
  import timer_pkg::*;
#(
  parameter int MACH_DIV_P   = MACH_DIV,
  parameter int CLKOUT_DIV_P = CLKOUT_DIV
) (
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    SRST_IN,
  input  wire timer_pkg::timer_ctrl_t  CTRL_IN,
  input  wire logic                    COUNT_WR_IN,
  input  wire timer_pkg::byte_pair_t   COUNT_WDATA_IN,
  input  wire logic                    RELOAD_WR_IN,
  input  wire timer_pkg::byte_pair_t   RELOAD_WDATA_IN,
  input  wire timer_pkg::timer_flags_t FLAG_CLR_IN,
  input  wire logic                    IRQ_ENABLE_IN,
  input  wire logic                    TRIG_DIR_PIN_IN,
  input  wire logic                    COUNT_CLK_PIN_IN,
  output logic                         COUNT_CLK_PIN_OUT,
  output logic                         COUNT_CLK_PIN_OE_OUT,
  output timer_pkg::byte_pair_t        COUNT_OUT,
  output timer_pkg::byte_pair_t        RELOAD_OUT,
  output timer_pkg::timer_flags_t      FLAGS_OUT,
  output logic                         IRQ_OUT,
  output logic                         BAUD_TICK_OUT
);
  import timer_pkg::*;

  // ****************************************************************
  // local widths
  // ****************************************************************
  localparam int MACH_W   = (MACH_DIV_P > 1) ? $clog2(MACH_DIV_P) : 1;
  localparam int FAST_W   = (CLKOUT_DIV_P > 1) ? $clog2(CLKOUT_DIV_P) : 1;
  localparam logic [MACH_W-1:0] MACH_LAST = MACH_W'(MACH_DIV_P - 1);
  localparam logic [FAST_W-1:0] FAST_LAST = FAST_W'(CLKOUT_DIV_P - 1);
  localparam logic [MACH_W-1:0] MACH_ONE  = MACH_W'(1);
  localparam logic [FAST_W-1:0] FAST_ONE  = FAST_W'(1);
  localparam logic [MACH_W-1:0] MACH_ZERO = '0;
  localparam logic [FAST_W-1:0] FAST_ZERO = '0;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [MACH_W-1:0] mach_cnt;
  logic [FAST_W-1:0] fast_cnt;
  logic [15:0]       count;
  logic [15:0]       reload;
  timer_flags_t      flags;
  logic              clk_level;
  logic              irq;
  logic              baud_tick;

  logic [15:0]       next_count;
  logic [15:0]       next_reload;
  timer_flags_t      next_flags;
  logic              next_irq;
  logic              next_clk_toggle;
  logic              next_baud_tick;

  // ****************************************************************
  // mode decoding
  // ****************************************************************
  function automatic timer_mode_t decode_mode(input timer_ctrl_t c);
    timer_mode_t m;
    if ((c.clock_out_enable && !c.counter_select) || c.baud_mode) begin
      m = MODE_FAST;
    end else if (c.capture_mode) begin
      m = MODE_CAPTURE;
    end else if (c.down_count_enable) begin
      m = MODE_UPDOWN;
    end else begin
      m = MODE_RELOAD_UP;
    end
    return m;
  endfunction : decode_mode

  timer_ctrl_t ctrl_eff;
  timer_mode_t mode;
  logic        clkout_active;
  logic        mach_tick;
  logic        fast_tick;
  logic        trig_level;
  logic        trig_fall;
  logic        cnt_pin_fall;
  logic        step;
  logic        at_max;
  logic        at_reload;
  logic [15:0] count_inc_wrap;

  assign mode          = decode_mode(ctrl_eff);
  assign clkout_active = CTRL_IN.clock_out_enable & ~CTRL_IN.counter_select;
  assign mach_tick     = (mach_cnt == MACH_LAST);
  assign fast_tick     = (fast_cnt == FAST_LAST);
  assign at_max        = (count == CNT_MAX);
  assign at_reload     = (count == reload);

  // ****************************************************************
  // control qualification
  // ****************************************************************
  // down-counting is masked only while reset is held; after reset the mode follows CTRL_IN
  always_comb begin
    ctrl_eff = CTRL_IN;
    if (SRST_IN) begin
      ctrl_eff.down_count_enable = 1'b0;
    end
  end

  // ****************************************************************
  // rate dividers
  // ****************************************************************
  // machine-cycle and fast-step enables from the oscillator clock
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      mach_cnt <= MACH_ZERO;
      fast_cnt <= FAST_ZERO;
    end else begin
      mach_cnt <= mach_tick ? MACH_ZERO : mach_cnt + MACH_ONE;
      fast_cnt <= fast_tick ? FAST_ZERO : fast_cnt + FAST_ONE;
    end
  end

  // ****************************************************************
  // pin front ends
  // ****************************************************************
  // trigger/direction pin, sampled once per machine cycle
  pin_edge_sync u_trig_sync (
    .clk_in       (CLK_SYS_IN),
    .srst_in      (SRST_IN),
    .sample_en_in (mach_tick),
    .pin_in       (TRIG_DIR_PIN_IN),
    .level_out    (trig_level),
    .fall_out     (trig_fall)
  );

  // external count input shares the clock-out pin
  pin_edge_sync u_count_sync (
    .clk_in       (CLK_SYS_IN),
    .srst_in      (SRST_IN),
    .sample_en_in (mach_tick),
    .pin_in       (COUNT_CLK_PIN_IN),
    .level_out    (),
    .fall_out     (cnt_pin_fall)
  );

  // ****************************************************************
  // count step selection
  // ****************************************************************
  // fast modes step at half the oscillator, others per machine cycle or pin edge
  assign step = CTRL_IN.run_control &
                ((mode == MODE_FAST)       ? fast_tick :
                 CTRL_IN.counter_select    ? cnt_pin_fall :
                 mach_tick);
  assign count_inc_wrap = count + CNT_ONE;

  // ****************************************************************
  // next-state logic for count, reload pair and flags
  // ****************************************************************
  // one case per operating mode; software writes are applied afterwards
  always_comb begin
    logic ovf_set;
    logic exf_set;
    logic exf_tog;
    logic roll;
    ovf_set     = 1'b0;
    exf_set     = 1'b0;
    exf_tog     = 1'b0;
    roll        = 1'b0;
    next_count  = count;
    next_reload = reload;
    case (mode)
      MODE_CAPTURE: begin
        // the count wraps through zero; a capture leaves counting undisturbed
        if (step) begin
          next_count = count_inc_wrap;
          ovf_set    = at_max;
        end
        if (CTRL_IN.external_trigger_enable && trig_fall) begin
          next_reload = count;
          exf_set     = 1'b1;
        end
      end
      MODE_RELOAD_UP: begin
        if (step) begin
          next_count = at_max ? reload : count_inc_wrap;
          ovf_set    = at_max;
        end
        // a trigger fall in the overflow cycle just reloads too, setting both flags
        if (CTRL_IN.external_trigger_enable && trig_fall) begin
          next_count = reload;
          exf_set    = 1'b1;
        end
      end
      MODE_UPDOWN: begin
        // direction follows the synchronised pin level, not its edges
        if (step && trig_level) begin
          next_count = at_max ? reload : count_inc_wrap;
          ovf_set    = at_max;
          exf_tog    = at_max;
        end else if (step) begin
          next_count = at_reload ? CNT_MAX : count - CNT_ONE;
          ovf_set    = at_reload;
          exf_tog    = at_reload;
        end
      end
      MODE_FAST: begin
        // shared counter for clock-out and baud ticks, no flags set
        if (step) begin
          next_count = at_max ? reload : count_inc_wrap;
          roll       = at_max;
        end
      end
      default: begin
        next_count = count;
      end
    endcase
    // a software count write beats any hardware change in the same cycle
    if (COUNT_WR_IN) begin
      next_count = COUNT_WDATA_IN;
    end
    // a capture in the same cycle beats a software reload write
    if (RELOAD_WR_IN && !(mode == MODE_CAPTURE && exf_set)) begin
      next_reload = RELOAD_WDATA_IN;
    end
    // a hardware set in the clearing cycle wins; only software clears, except the up/down toggle of the event flag
    next_flags.overflow_flag = ovf_set |
                               (flags.overflow_flag & ~FLAG_CLR_IN.overflow_flag);
    next_flags.external_event_flag = exf_set |
      ((flags.external_event_flag & ~FLAG_CLR_IN.external_event_flag) ^ exf_tog);
    next_clk_toggle = roll & clkout_active;
    next_baud_tick  = roll & CTRL_IN.baud_mode;
  end

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  // event flag is a count bit in up/down mode and stays out of the request
  // built from the next flags so the request moves together with the flags
  assign next_irq = IRQ_ENABLE_IN &
                    (next_flags.overflow_flag |
                     (next_flags.external_event_flag & (mode != MODE_UPDOWN)));

  // ****************************************************************
  // registers
  // ****************************************************************
  // count, reload pair and flags
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      count  <= CNT_RESET;
      reload <= RELOAD_RESET;
      flags  <= FLAGS_RESET;
    end else begin
      count  <= next_count;
      reload <= next_reload;
      flags  <= next_flags;
    end
  end

  // clock-out level, baud tick and interrupt request
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      clk_level <= 1'b0;
      baud_tick <= 1'b0;
      irq       <= 1'b0;
    end else begin
      clk_level <= clk_level ^ next_clk_toggle;
      baud_tick <= next_baud_tick;
      irq       <= next_irq;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // pin driven only while clock-out is selected; it holds level when stopped
  assign COUNT_CLK_PIN_OUT    = clk_level;
  assign COUNT_CLK_PIN_OE_OUT = clkout_active;
  assign COUNT_OUT            = count;
  assign RELOAD_OUT           = reload;
  assign FLAGS_OUT            = flags;
  assign IRQ_OUT              = irq;
  assign BAUD_TICK_OUT        = baud_tick;

endmodule : capture_reload_timer

//--- verilog/pin_edge_sync.sv
// pin synchroniser with falling-edge detection sampled on an enable
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic sample_en_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);

  logic sync_first;
  logic sync_second;
  logic prev_sample;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
    end else begin
      sync_first  <= pin_in;
      sync_second <= sync_first;
    end
  end

  // previous sample taken once per sampling enable
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_sample <= 1'b1;
    end else if (sample_en_in) begin
      prev_sample <= sync_second;
    end
  end

  // high then low across two samples is one falling edge
  assign level_out = sync_second;
  assign fall_out  = sample_en_in & prev_sample & ~sync_second;

endmodule : pin_edge_sync
